// File: verilog/ifeu_pkg.sv
// Package for the interrupt flag and enable unit.
// Assumes an 8-bit zero-page bus with byte addresses.
package ifeu_pkg;
    localparam int IFEU_ADDR_W = 8;
    localparam int IFEU_DATA_W = 8;
    localparam int IFEU_NUM_FLAGS = 8;
    localparam logic [7:0] IFEU_ADDR_CLEAR_PORT = 8'h10;
    localparam logic [7:0] IFEU_ADDR_FLAGS = 8'h11;
    localparam logic [7:0] IFEU_ADDR_ENABLES = 8'h12;
    localparam logic [7:0] IFEU_ADDR_CNTA_LOW = 8'h18;
    localparam logic [7:0] IFEU_ADDR_CNTA_LOAD = 8'h1a;
    localparam logic [7:0] IFEU_ADDR_CNTB_LOW = 8'h1c;
    localparam logic [7:0] IFEU_ADDR_CNTB_LOAD = 8'h1e;
    localparam logic [7:0] IFEU_CLEAR_PORT_READ = 8'hff;
    localparam logic [7:0] IFEU_RESET_BYTE = 8'h00;
    localparam logic [3:0] IFEU_EDGE_MASK = 4'hf;
    localparam int IFEU_BIT_CNTA = 4;
    localparam int IFEU_BIT_CNTB = 5;
    localparam int IFEU_BIT_RX = 6;
    localparam int IFEU_BIT_TX = 7;
    localparam int IFEU_SS_TX_EMPTY = 6;
    localparam int IFEU_SS_TX_BUSY = 5;
    localparam int IFEU_SS_TX_END = 7;
endpackage : ifeu_pkg

// File: verilog/ifeu_edge_det.sv
// Edge detector for one pin: two-stage synchroniser plus compare.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module ifeu_edge_det #(
    parameter bit RISING = 1'b1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pin and detected event.
    input wire logic pin,
    output logic edge_seen
);
    logic sync_a;
    logic sync_b;
    logic prev;

    // Synchronise the pin and keep the previous sample.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    // Compare current and previous samples, one event per edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_seen <= 1'b0;
        end else begin
            edge_seen <= RISING ? (sync_b & ~prev) : (~sync_b & prev);
        end
    end
endmodule : ifeu_edge_det

// File: verilog/ifeu_top.sv
// Interrupt flag and enable unit: eight flags, enable mask, request output.
// Assumes the core drives a synchronous zero-page bus with one-cycle strobes,
// and that reads return data in the cycle after the strobe.
`timescale 1ns/1ns
module ifeu_top
    import ifeu_pkg::*;
(
    // Clock and chip reset.
    input wire logic clk,
    input wire logic rst_n,
    // Zero-page bus from the core.
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Edge pins.
    input wire logic edge_pin_0,
    input wire logic edge_pin_1,
    input wire logic edge_pin_2,
    input wire logic edge_pin_3,
    // Events from counters and serial port on clk.
    input wire logic cnta_underflow,
    input wire logic cntb_underflow,
    input wire logic [7:0] serial_status_bits,
    // Maskable request to the core, active low.
    output logic irq_n
);
    logic [7:0] interrupt_flags;
    logic [7:0] interrupt_enables;
    logic [3:0] edge_pins;
    logic [3:0] edge_hits;
    logic [7:0] next_flags;
    logic wr_clear_port;
    logic rd_cnta_low;
    logic rd_cntb_low;
    logic wr_cnta_load;
    logic wr_cntb_load;
    logic rx_cond;
    logic tx_cond;

    // Edge flags sit in the low bits, one per pin, below the counter flags.
    localparam int NUM_EDGE_PINS = $bits(IFEU_EDGE_MASK);

    // Widths must agree with the bus byte; refuse a layout the decode cannot serve.
    if (IFEU_NUM_FLAGS != IFEU_DATA_W || NUM_EDGE_PINS > IFEU_BIT_CNTA) begin : g_layout_check
        $error("Flag layout does not fit the bus byte.");
    end

    assign edge_pins = {edge_pin_3, edge_pin_2, edge_pin_1, edge_pin_0};

    // One detector per edge pin; pins 0 and 1 rising, 2 and 3 falling.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EDGE_PINS; gi++) begin : g_edge
            ifeu_edge_det #(.RISING(gi < NUM_EDGE_PINS / 2)) u_det (
                .clk(clk),
                .rst_n(rst_n),
                .pin(edge_pins[gi]),
                .edge_seen(edge_hits[gi])
            );
        end
    endgenerate

    // Decode bus strobes that act on the flags.
    assign wr_clear_port = bus_wr && (bus_addr == IFEU_ADDR_FLAGS);
    assign rd_cnta_low = bus_rd && (bus_addr == IFEU_ADDR_CNTA_LOW);
    assign rd_cntb_low = bus_rd && (bus_addr == IFEU_ADDR_CNTB_LOW);
    assign wr_cnta_load = bus_wr && (bus_addr == IFEU_ADDR_CNTA_LOAD);
    assign wr_cntb_load = bus_wr && (bus_addr == IFEU_ADDR_CNTB_LOAD);
    assign rx_cond = |serial_status_bits[3:0];
    assign tx_cond = (serial_status_bits[IFEU_SS_TX_EMPTY] &
                      ~serial_status_bits[IFEU_SS_TX_BUSY]) |
                     serial_status_bits[IFEU_SS_TX_END];

    // Next flag value; a new event wins over a clear in the same cycle.
    always_comb begin
        next_flags = interrupt_flags;
        for (int i = 0; i < NUM_EDGE_PINS; i++) begin
            if (wr_clear_port && !bus_wdata[i]) begin
                next_flags[i] = 1'b0;
            end
            if (edge_hits[i]) begin
                next_flags[i] = 1'b1;
            end
        end
        if (rd_cnta_low || wr_cnta_load) begin
            next_flags[IFEU_BIT_CNTA] = 1'b0;
        end
        if (cnta_underflow) begin
            next_flags[IFEU_BIT_CNTA] = 1'b1;
        end
        if (rd_cntb_low || wr_cntb_load) begin
            next_flags[IFEU_BIT_CNTB] = 1'b0;
        end
        if (cntb_underflow) begin
            next_flags[IFEU_BIT_CNTB] = 1'b1;
        end
        next_flags[IFEU_BIT_RX] = rx_cond;
        next_flags[IFEU_BIT_TX] = tx_cond;
    end

    // Flag register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_flags <= IFEU_RESET_BYTE;
        end else begin
            interrupt_flags <= next_flags;
        end
    end

    // Enable register, written whole at its address.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enables <= IFEU_RESET_BYTE;
        end else if (bus_wr && bus_addr == IFEU_ADDR_ENABLES) begin
            interrupt_enables <= bus_wdata;
        end
    end

    // Read data; reads have no effect on edge flags.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= IFEU_RESET_BYTE;
        end else if (bus_rd) begin
            unique case (bus_addr)
                IFEU_ADDR_CLEAR_PORT: bus_rdata <= IFEU_CLEAR_PORT_READ;
                IFEU_ADDR_FLAGS: bus_rdata <= interrupt_flags;
                IFEU_ADDR_ENABLES: bus_rdata <= interrupt_enables;
                default: bus_rdata <= IFEU_RESET_BYTE;
            endcase
        end
    end

    // Request stays low while any enabled flag remains set. It is built from the next flag
    // value so that it moves on the same edge as the flag; an enable write takes one edge
    // more because the enable register itself is registered.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(next_flags & interrupt_enables);
        end
    end

    // Assertions guarding the documented behaviour.
    a_irq_follows_mask: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (irq_n == ~|($past(next_flags) & $past(interrupt_enables))))
        else $error("Request does not match enabled flags.");

    a_irq_held_pending: assert property (@(posedge clk) disable iff (!rst_n)
        (|(interrupt_flags & $past(interrupt_enables))) && $past(rst_n) |-> !irq_n)
        else $error("Request released while a condition is pending.");

    a_flag_read_value: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rd && bus_addr == IFEU_ADDR_FLAGS |=> bus_rdata == $past(interrupt_flags))
        else $error("Flag read returned wrong value.");

    a_read_keeps_edges: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rd && !bus_wr |=> (interrupt_flags[3:0] & $past(interrupt_flags[3:0]))
            == $past(interrupt_flags[3:0]))
        else $error("Read altered an edge flag.");

    a_clear_port_ff: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rd && bus_addr == IFEU_ADDR_CLEAR_PORT |=> bus_rdata == IFEU_CLEAR_PORT_READ)
        else $error("Clear port did not read all ones.");

    a_zero_clears_edge: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clear_port && !bus_wdata[0] && !edge_hits[0] |=> !interrupt_flags[0])
        else $error("Zero write failed to clear edge flag.");

    a_one_keeps_edge: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clear_port && bus_wdata[2] && interrupt_flags[2] |=> interrupt_flags[2])
        else $error("One write cleared an edge flag.");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        bus_wr && bus_addr == IFEU_ADDR_ENABLES |=> interrupt_enables == $past(bus_wdata))
        else $error("Enable write not taken.");

    a_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(bus_wr && bus_addr == IFEU_ADDR_ENABLES) |=> $stable(interrupt_enables))
        else $error("Enable changed without a write.");

    a_rise_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hits[1] |=> interrupt_flags[1])
        else $error("Rising edge did not set flag.");

    a_fall_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hits[3] |=> interrupt_flags[3])
        else $error("Falling edge did not set flag.");

    a_cnta_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_cnta_low || wr_cnta_load) && !cnta_underflow |=> !interrupt_flags[IFEU_BIT_CNTA])
        else $error("Counter A flag not cleared.");

    a_cntb_set: assert property (@(posedge clk) disable iff (!rst_n)
        cntb_underflow |=> interrupt_flags[IFEU_BIT_CNTB])
        else $error("Counter B flag not set.");

    a_rx_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 interrupt_flags[IFEU_BIT_RX] == $past(|serial_status_bits[3:0]))
        else $error("Receiver flag wrong.");

    a_tx_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 interrupt_flags[IFEU_BIT_TX] == $past(tx_cond))
        else $error("Transmitter flag wrong.");

    a_edge_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hits[0] |=> !edge_hits[0])
        else $error("Edge detector fired on consecutive cycles.");

    // The request follows the masked next-flag value one edge later, in both directions.
    a_irq_asserts: assert property (@(posedge clk) disable iff (!rst_n)
        (|(next_flags & interrupt_enables)) |=> !irq_n)
        else $error("Request not raised for an enabled flag.");

    a_irq_releases: assert property (@(posedge clk) disable iff (!rst_n)
        !(|(next_flags & interrupt_enables)) |=> irq_n)
        else $error("Request raised with no enabled flag.");

    // A partial clear must not drop the request while other sources remain.
    a_partial_clear: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clear_port && (|(next_flags & interrupt_enables)) |=> !irq_n)
        else $error("Partial clear released the request.");

    // Flag-register reads leave event flags in place and read data stands until the next read.
    a_read_no_clear: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rd && !bus_wr && bus_addr == IFEU_ADDR_FLAGS |=>
            (interrupt_flags[IFEU_BIT_CNTB:0] & $past(interrupt_flags[IFEU_BIT_CNTB:0]))
            == $past(interrupt_flags[IFEU_BIT_CNTB:0]))
        else $error("Flag read cleared an event flag.");

    a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_rd |=> $stable(bus_rdata))
        else $error("Read data changed without a read.");

    // A write to the clear port itself moves no edge flag down.
    a_clear_port_write: assert property (@(posedge clk) disable iff (!rst_n)
        bus_wr && bus_addr == IFEU_ADDR_CLEAR_PORT |=>
            (interrupt_flags[NUM_EDGE_PINS-1:0] & $past(interrupt_flags[NUM_EDGE_PINS-1:0]))
            == $past(interrupt_flags[NUM_EDGE_PINS-1:0]))
        else $error("Write to the clear port cleared an edge flag.");

    // The enable register reads back and a zero byte clears every enable.
    a_enables_read: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rd && bus_addr == IFEU_ADDR_ENABLES |=> bus_rdata == $past(interrupt_enables))
        else $error("Enable read returned wrong value.");

    a_enables_zero: assert property (@(posedge clk) disable iff (!rst_n)
        bus_wr && bus_addr == IFEU_ADDR_ENABLES && bus_wdata == IFEU_RESET_BYTE
            |=> interrupt_enables == IFEU_RESET_BYTE)
        else $error("Zero write left an enable set.");

    // Counter flags: set on underflow, cleared by their accesses, else held.
    a_cnta_set: assert property (@(posedge clk) disable iff (!rst_n)
        cnta_underflow |=> interrupt_flags[IFEU_BIT_CNTA])
        else $error("Counter A flag not set.");

    a_cntb_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_cntb_low || wr_cntb_load) && !cntb_underflow |=> !interrupt_flags[IFEU_BIT_CNTB])
        else $error("Counter B flag not cleared.");

    a_cnta_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cnta_underflow && !rd_cnta_low && !wr_cnta_load
            |=> interrupt_flags[IFEU_BIT_CNTA] == $past(interrupt_flags[IFEU_BIT_CNTA]))
        else $error("Counter A flag moved without an event.");

    a_cntb_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cntb_underflow && !rd_cntb_low && !wr_cntb_load
            |=> interrupt_flags[IFEU_BIT_CNTB] == $past(interrupt_flags[IFEU_BIT_CNTB]))
        else $error("Counter B flag moved without an event.");

    // The flag-register write only touches edge flags, never the counter flags.
    a_write_keeps_cnt: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clear_port && interrupt_flags[IFEU_BIT_CNTA] |=> interrupt_flags[IFEU_BIT_CNTA])
        else $error("Flag write cleared the counter flag.");

    // Serial flags follow their conditions one edge later: RX any of bits 3:0, TX on IFEU_SS_TX_END or on IFEU_SS_TX_EMPTY without IFEU_SS_TX_BUSY.
    a_rx_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (|serial_status_bits[3:0]) |=> interrupt_flags[IFEU_BIT_RX])
        else $error("Receiver flag not set.");

    a_rx_clear: assert property (@(posedge clk) disable iff (!rst_n)
        serial_status_bits[3:0] == 4'h0 |=> !interrupt_flags[IFEU_BIT_RX])
        else $error("Receiver flag not cleared.");

    a_tx_sets: assert property (@(posedge clk) disable iff (!rst_n)
        serial_status_bits[IFEU_SS_TX_END] |=> interrupt_flags[IFEU_BIT_TX])
        else $error("Transmitter flag not set.");

    a_tx_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !serial_status_bits[IFEU_SS_TX_EMPTY] && !serial_status_bits[IFEU_SS_TX_END]
            |=> !interrupt_flags[IFEU_BIT_TX])
        else $error("Transmitter flag not cleared.");

    // Per edge flag: a zero write clears it unless an edge lands in the same cycle,
    // a detected edge always sets it, and nothing else moves it.
    for (genvar gk = 0; gk < NUM_EDGE_PINS; gk++) begin : g_edge_checks
        a_zero_clears_bit: assert property (@(posedge clk) disable iff (!rst_n)
            wr_clear_port && !bus_wdata[gk] && !edge_hits[gk] |=> !interrupt_flags[gk])
            else $error("Zero write left an edge flag set.");

        a_edge_sets_bit: assert property (@(posedge clk) disable iff (!rst_n)
            edge_hits[gk] |=> interrupt_flags[gk])
            else $error("Detected edge did not set its flag.");

        a_one_keeps_bit: assert property (@(posedge clk) disable iff (!rst_n)
            wr_clear_port && bus_wdata[gk] && interrupt_flags[gk] |=> interrupt_flags[gk])
            else $error("One write cleared an edge flag.");

        a_edge_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
            !edge_hits[gk] && !(wr_clear_port && !bus_wdata[gk])
                |=> interrupt_flags[gk] == $past(interrupt_flags[gk]))
            else $error("Edge flag moved without an event.");
    end
endmodule : ifeu_top

// File: verif/ifeu_core_model.sv
// Core-side model: drives the zero-page bus with single-byte reads and writes.
// Assumes one-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/1ns
module ifeu_core_model (
    // Clock.
    input wire logic clk,
    // Zero-page bus to the unit.
    output logic [7:0] bus_addr,
    output logic bus_rd,
    output logic bus_wr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    // The bus starts idle with no strobe raised.
    initial begin
        bus_addr = 8'h00;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
    end
    // Read one byte; released lines take the inverse of the last value.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        @(posedge clk);
        #1 d = bus_rdata;
    endtask : rd
    // Write one byte, then let the edge that updates state pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~v;
        @(posedge clk);
        #1;
    endtask : wr
    // Bit clear: read the clear port, then write back with one bit zeroed.
    task automatic zero_page_bit_clear(input int b, output logic [7:0] d);
        rd(8'h10, d);
        wr(8'h11, d & ~(8'h01 << b));
    endtask : zero_page_bit_clear
endmodule : ifeu_core_model

// File: verif/ifeu_top_bench.sv
// Testbench for the interrupt flag and enable unit.
// Assumes the core model drives the bus; the bench drives pins and events.
`timescale 1ns/1ns
module ifeu_top_bench;
    import ifeu_pkg::*;
    logic clk, rst_n, bus_rd, bus_wr, cnta_underflow, cntb_underflow, irq_n;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, serial_status_bits, d;
    logic [3:0] pins;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    ifeu_top i_ifeu_top (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .edge_pin_0(pins[0]), .edge_pin_1(pins[1]), .edge_pin_2(pins[2]),
        .edge_pin_3(pins[3]), .cnta_underflow(cnta_underflow),
        .cntb_underflow(cntb_underflow), .serial_status_bits(serial_status_bits),
        .irq_n(irq_n));
    ifeu_core_model i_ifeu_core_model (.clk(clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Compares a byte result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8
    // Compares the request line.
    task automatic chk_irq(input logic exp);
        n_tests++;
        if (irq_n !== exp) begin
            failures++;
            $display("CHECK FAILED %0t request %b expected %b", $time, irq_n, exp);
        end
    endtask : chk_irq
    // Reads a register and compares it.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_ifeu_core_model.rd(a, d);
        chk8(d, exp);
    endtask : rdchk
    // Gives one pin a two-cycle pulse and lets the detector settle.
    task automatic pulse(input int i);
        @(posedge clk);
        pins[i] <= ~pins[i];
        repeat (2) @(posedge clk);
        pins[i] <= ~pins[i];
        repeat (6) @(posedge clk);
    endtask : pulse
    task automatic t_reset;
        rdchk(8'h11, 8'h00);
        rdchk(8'h12, 8'h00);
        chk_irq(1'b1);
        i_ifeu_core_model.wr(8'h12, 8'ha5);
        rdchk(8'h12, 8'ha5);
        i_ifeu_core_model.wr(8'h12, 8'h0f);
        rdchk(8'h12, 8'h0f);
        i_ifeu_core_model.wr(8'h12, 8'h00);
    endtask : t_reset
    task automatic t_edges;
        @(posedge clk);
        pins <= 4'b1001;
        repeat (6) @(posedge clk);
        rdchk(8'h11, 8'h05);
        rdchk(8'h11, 8'h05);
        i_ifeu_core_model.zero_page_bit_clear(0, d);
        chk8(d, 8'hff);
        rdchk(8'h11, 8'h04);
        i_ifeu_core_model.wr(8'h11, 8'hff);
        rdchk(8'h11, 8'h04);
        @(posedge clk);
        pins <= 4'b1100;
        repeat (6) @(posedge clk);
        rdchk(8'h11, 8'h04);
        i_ifeu_core_model.zero_page_bit_clear(2, d);
        rdchk(8'h11, 8'h00);
        pulse(3);
        rdchk(8'h11, 8'h08);
        i_ifeu_core_model.zero_page_bit_clear(3, d);
        rdchk(8'h11, 8'h00);
    endtask : t_edges
    task automatic t_irq;
        i_ifeu_core_model.wr(8'h12, 8'h01);
        pulse(1);
        chk_irq(1'b1);
        rdchk(8'h11, 8'h02);
        pulse(0);
        chk_irq(1'b0);
        i_ifeu_core_model.wr(8'h12, 8'h03);
        i_ifeu_core_model.zero_page_bit_clear(0, d);
        chk_irq(1'b0);
        i_ifeu_core_model.zero_page_bit_clear(1, d);
        chk_irq(1'b1);
    endtask : t_irq
    task automatic t_counters;
        logic [7:0] clr [4] = '{8'h18, 8'h1a, 8'h1c, 8'h1e};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            if (i < 2) cnta_underflow <= 1'b1;
            else cntb_underflow <= 1'b1;
            @(posedge clk);
            cnta_underflow <= 1'b0;
            cntb_underflow <= 1'b0;
            rdchk(8'h11, (i < 2) ? 8'h10 : 8'h20);
            if (i % 2 == 0) i_ifeu_core_model.rd(clr[i], d);
            else i_ifeu_core_model.wr(clr[i], 8'h5a);
            rdchk(8'h11, 8'h00);
        end
    endtask : t_counters
    task automatic t_serial;
        logic [7:0] v [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h60, 8'h80, 8'h00};
        logic [7:0] e [8] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h80, 8'h00, 8'h80, 8'h00};
        i_ifeu_core_model.wr(8'h12, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            serial_status_bits <= v[i];
            rdchk(8'h11, e[i]);
            chk_irq(e[i] == 8'h00);
        end
    endtask : t_serial
    // Reset in mid-run with a flag pending and every enable set.
    task automatic t_midreset;
        i_ifeu_core_model.wr(8'h12, 8'hff);
        @(posedge clk);
        cntb_underflow <= 1'b1;
        @(posedge clk);
        cntb_underflow <= 1'b0;
        repeat (2) @(posedge clk);
        chk_irq(1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h12, 8'h00);
        rdchk(8'h11, 8'h00);
        chk_irq(1'b1);
    endtask : t_midreset
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        pins = 4'b1100;
        cnta_underflow = 1'b0;
        cntb_underflow = 1'b0;
        serial_status_bits = 8'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_edges();
        t_irq();
        t_counters();
        t_serial();
        t_midreset();
        give_verdict();
    end
endmodule : ifeu_top_bench
